// [common/lmw_pkg.sv]
// shared types and constants for the three-transceiver LIN mode, wake and fault control
package lmw_pkg;
	// ==========================================================
	// transceiver modes (two-bit mode field codes)
	typedef enum logic [1:0] {
		LMW_OFF    = 2'h0,
		LMW_WAKE   = 2'h1,
		LMW_RXONLY = 2'h2,
		LMW_NORMAL = 2'h3
	} lmw_mode_t;

	// chip operating modes as seen by this block
	typedef enum logic [2:0] {
		LMW_CHIP_NORMAL   = 3'h0,
		LMW_CHIP_STOP     = 3'h1,
		LMW_CHIP_SLEEP    = 3'h2,
		LMW_CHIP_RESTART  = 3'h3,
		LMW_CHIP_FAILSAFE = 3'h4
	} lmw_chip_t;

	// wake detector states
	typedef enum logic [1:0] {
		LMW_WK_IDLE,
		LMW_WK_DOM,
		LMW_WK_LONG,
		LMW_WK_DONE
	} lmw_wk_state_t;

	// ==========================================================
	// geometry
	localparam int LMW_NUM_XCVR = 3;
	localparam int LMW_FIFO_W   = 4;
	localparam int LMW_FIFO_D   = 8;

	// ==========================================================
	// timing: clock at 40 MHz
	localparam int LMW_CLK_KHZ         = 40000;
	localparam int LMW_WAKE_FILT_US    = 30;   // filter window is 30 to 150 us
	localparam int LMW_WAKE_FILT_MAX_US = 150;
	localparam int LMW_WAKE_FILT_CYC   = LMW_WAKE_FILT_US * LMW_CLK_KHZ / 1000;
	localparam int LMW_ENABLE_TIME_US  = 10;   // transmitter enabling time, plain default
	localparam int LMW_ENABLE_CYC      = LMW_ENABLE_TIME_US * LMW_CLK_KHZ / 1000;
	localparam int LMW_DOM_TO_MS       = 12;   // dominant time-out, plain default
	localparam int LMW_DOM_TO_CYC      = LMW_DOM_TO_MS * LMW_CLK_KHZ;
	localparam int LMW_CNT_W           = 20;

	// ==========================================================
	// reset values
	localparam logic LMW_RST_LOW_SLOPE = 1'b0;
	localparam logic LMW_RST_FLASH     = 1'b0;

	// record pushed into the event fifo: index of the lowest transceiver with an event, wake and fail ORed over all three
	typedef struct packed {
		logic [1:0] idx;
		logic       wake;
		logic       fail;
	} lmw_event_t;
endpackage

// [logic/lmw_fifo.sv]
// parameterised valid/ready fifo for the transceiver event records
`timescale 1ns/1ps
module lmw_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// fill side
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	// drain side
	output logic                  out_valid_o,
	output logic [WIDTH-1:0]      out_data_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      cnt_ff;
	wire              do_wr = in_valid_i && in_ready_o;
	wire              do_rd = out_valid_o && out_ready_i;

	// honest flags from the occupancy count
	assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o  = mem_ff[rd_ff];

	// storage has no reset, only pointers and count do
	always_ff @(posedge clk_i) begin
		if (do_wr) begin
			mem_ff[wr_ff] <= in_data_i;
		end
	end

	// pointer and count update
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (do_wr) wr_ff <= AW'(wr_ff + 1'b1);
			if (do_rd) rd_ff <= AW'(rd_ff + 1'b1);
			cnt_ff <= (AW+1)'(cnt_ff + do_wr - do_rd);
		end
	end
endmodule

// [logic/lmw_ctrl.sv]
// mode, wake and fault control for three LIN transceivers
`timescale 1ns/1ps
module lmw_ctrl
	import lmw_pkg::*;
#(
	parameter int DOM_TO_CYC = LMW_DOM_TO_CYC
) (
	// clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    reset_n_i,
	// chip mode and supply
	input  wire lmw_chip_t               chip_mode_i,
	input  wire logic                    chip_mode_write_i,
	input  wire logic                    supply_uv_i,
	input  wire logic                    watchdog_disabled_i,
	input  wire logic                    watchdog_on_bus_wake_i,
	// spi-side configuration
	input  wire logic                    spi_cs_n_i,
	input  wire logic                    mode_write_i,
	input  wire logic [5:0]              mode_wdata_i,
	input  wire logic                    low_slope_wdata_i,
	input  wire logic                    flash_wdata_i,
	input  wire logic                    opt_write_i,
	input  wire logic                    transmit_timeout_enable_i,
	input  wire logic [2:0]              fail_clear_i,
	input  wire logic                    wake_source_clear_i,
	// microcontroller and bus pins
	input  wire logic [2:0]              lin_transmit_in_i,
	input  wire logic [2:0]              bus_level_i,
	output logic      [2:0]              lin_receive_out_o,
	output logic      [2:0]              bus_drive_low_o,
	// status and requests
	output logic      [5:0]              mode_fields_o,
	output logic      [2:0]              failure_flags_o,
	output logic                         wake_source_status_o,
	output logic                         interrupt_o,
	output logic                         restart_request_o,
	output logic                         watchdog_enable_o,
	output logic                         low_slope_select_o,
	output logic                         slope_off_o,
	// event stream
	output logic                         event_valid_o,
	output logic [LMW_FIFO_W-1:0]        event_data_o,
	input  wire logic                    event_ready_i
);
	// ==========================================================
	// input synchronisers for pins from outside
	logic [2:0] tx_s1_ff, tx_s2_ff, bus_s1_ff, bus_s2_ff, uv_s;
	logic       uv_s1_ff, uv_s2_ff, cs_s1_ff, cs_s2_ff, cs_d_ff;

	// two flops on every pin before use
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_s1_ff  <= 3'h7;
			tx_s2_ff  <= 3'h7;
			bus_s1_ff <= 3'h7;
			bus_s2_ff <= 3'h7;
			uv_s1_ff  <= 1'b0;
			uv_s2_ff  <= 1'b0;
			cs_s1_ff  <= 1'b1;
			cs_s2_ff  <= 1'b1;
			cs_d_ff   <= 1'b1;
		end else begin
			tx_s1_ff  <= lin_transmit_in_i;
			tx_s2_ff  <= tx_s1_ff;
			bus_s1_ff <= bus_level_i;
			bus_s2_ff <= bus_s1_ff;
			uv_s1_ff  <= supply_uv_i;
			uv_s2_ff  <= uv_s1_ff;
			cs_s1_ff  <= spi_cs_n_i;
			cs_s2_ff  <= cs_s1_ff;
			cs_d_ff   <= cs_s2_ff;
		end
	end

	// ==========================================================
	// shared options
	wire cs_rise     = cs_s2_ff && !cs_d_ff;
	wire chip_normal = (chip_mode_i == LMW_CHIP_NORMAL);
	wire chip_stop   = (chip_mode_i == LMW_CHIP_STOP);
	wire chip_sleep  = (chip_mode_i == LMW_CHIP_SLEEP);
	wire chip_fs     = (chip_mode_i == LMW_CHIP_FAILSAFE);
	// stop commanded again also rearms, so a write counts, not only a change
	wire rearm_all   = chip_mode_write_i && (chip_stop || chip_sleep || chip_fs);
	logic low_slope_ff, flash_ff, pend_ls_ff, pend_fl_ff, to_en_ff;
	assign uv_s = {3{uv_s2_ff}};

	// slope bits stage on write in chip normal only, apply on select rise
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			low_slope_ff <= LMW_RST_LOW_SLOPE;
			flash_ff     <= LMW_RST_FLASH;
			pend_ls_ff   <= LMW_RST_LOW_SLOPE;
			pend_fl_ff   <= LMW_RST_FLASH;
			to_en_ff     <= 1'b1;
		end else begin
			if (opt_write_i && chip_normal) begin
				pend_ls_ff <= low_slope_wdata_i;
				pend_fl_ff <= flash_wdata_i;
			end
			if (opt_write_i) to_en_ff <= transmit_timeout_enable_i;
			if (cs_rise) begin
				low_slope_ff <= pend_ls_ff;
				flash_ff     <= pend_fl_ff;
			end
		end
	end

	// ==========================================================
	// per-transceiver logic
	logic [2:0] wake_ev, fail_ev, drive_n, rx_n;
	lmw_mode_t  mode_ff [LMW_NUM_XCVR];

	genvar gi;
	generate
		for (gi = 0; gi < LMW_NUM_XCVR; gi++) begin : g_x
			lmw_wk_state_t   wk_ff;
			logic            woken_ff, armed_ff, en_done_ff, hold_ff, txto_ff;
			logic [LMW_CNT_W-1:0] en_cnt_ff, wk_cnt_ff, txc_ff, busc_ff;
			lmw_mode_t       req;
			logic            req_ok;
			wire             tx_dom   = !tx_s2_ff[gi];
			wire             bus_dom  = !bus_s2_ff[gi];
			wire             is_norm  = (mode_ff[gi] == LMW_NORMAL);
			wire             is_rx    = (mode_ff[gi] == LMW_RXONLY);
			wire             is_wake  = (mode_ff[gi] == LMW_WAKE);
			wire             tx_to    = to_en_ff && (txc_ff >= LMW_CNT_W'(DOM_TO_CYC));
			wire             bus_to   = (busc_ff >= LMW_CNT_W'(DOM_TO_CYC));
			wire             mode_chg = mode_write_i && (req != mode_ff[gi]) && req_ok;

			// legality of the requested mode in the current chip mode
			assign req    = lmw_mode_t'(mode_wdata_i[2*gi +: 2]);
			assign req_ok = (req == LMW_OFF)
				|| (req == LMW_NORMAL && chip_normal)
				|| (req == LMW_RXONLY && (chip_normal || chip_stop))
				|| (req == LMW_WAKE && !chip_fs);

			// mode field: starts off, fail-safe forces wake capable
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					mode_ff[gi] <= LMW_OFF;
				end else if (chip_fs) begin
					mode_ff[gi] <= LMW_WAKE;
				end else if (mode_write_i && req_ok) begin
					mode_ff[gi] <= req; // woken state leaves the code at wake
				end
			end

			// enabling time and first-edge gate after entering normal
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					en_cnt_ff  <= '0;
					en_done_ff <= 1'b0;
					hold_ff    <= 1'b1;
				end else if (!is_norm) begin
					en_cnt_ff  <= '0;
					en_done_ff <= 1'b0;
					hold_ff    <= 1'b1;
				end else if (!en_done_ff) begin
					en_cnt_ff  <= LMW_CNT_W'(en_cnt_ff + 1'b1);
					en_done_ff <= (en_cnt_ff >= LMW_CNT_W'(LMW_ENABLE_CYC - 1));
				end else if (!tx_dom) begin
					hold_ff <= 1'b0; // dominant stays blocked until input went high
				end
			end

			// transmit and bus dominant timers
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					txc_ff  <= '0;
					busc_ff <= '0;
					txto_ff <= 1'b0;
				end else begin
					txc_ff  <= (tx_dom && !tx_to) ? LMW_CNT_W'(txc_ff + 1'b1) :
						(tx_dom ? txc_ff : '0);
					busc_ff <= (bus_dom && (is_norm || is_rx) && !bus_to) ?
						LMW_CNT_W'(busc_ff + 1'b1) : ((bus_dom && (is_norm || is_rx)) ? busc_ff : '0);
					txto_ff <= tx_dom && (txto_ff || tx_to); // released on rise
				end
			end

			// wake detector: fall, dominant past filter, rise
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					wk_ff     <= LMW_WK_IDLE;
					wk_cnt_ff <= '0;
					woken_ff  <= 1'b0;
					armed_ff  <= 1'b1;
				end else if (!is_wake || mode_chg || rearm_all) begin
					wk_ff     <= LMW_WK_IDLE; // off ignores bus
					wk_cnt_ff <= '0;
					woken_ff  <= 1'b0;
					armed_ff  <= 1'b1;
				end else begin
					case (wk_ff)
						LMW_WK_IDLE: begin
							wk_cnt_ff <= '0;
							if (!bus_dom) wk_ff <= LMW_WK_DOM; // need recessive first
						end
						LMW_WK_DOM: begin
							wk_cnt_ff <= '0;
							if (bus_dom && armed_ff) wk_ff <= LMW_WK_LONG;
						end
						LMW_WK_LONG: begin
							if (!bus_dom) begin
								wk_ff <= (wk_cnt_ff >= LMW_CNT_W'(LMW_WAKE_FILT_CYC)) ?
									LMW_WK_DONE : LMW_WK_DOM;
							end else if (wk_cnt_ff < LMW_CNT_W'(LMW_WAKE_FILT_CYC)) begin
								wk_cnt_ff <= LMW_CNT_W'(wk_cnt_ff + 1'b1);
							end
						end
						LMW_WK_DONE: begin
							woken_ff <= 1'b1;
							armed_ff <= 1'b0;
							wk_ff    <= LMW_WK_IDLE;
						end
						default: wk_ff <= LMW_WK_IDLE;
					endcase
				end
			end

			// per-transceiver combinational results
			assign wake_ev[gi] = (wk_ff == LMW_WK_DONE);
			assign fail_ev[gi] = tx_to || bus_to;
			// driver only in normal, enabled, past first edge, no time-out, no undervoltage
			assign drive_n[gi] = is_norm && en_done_ff && !hold_ff && !txto_ff && !tx_to
				&& !uv_s[gi] && tx_dom;
			// receive path: off shows recessive, wake pulls low after wake
			assign rx_n[gi] = (is_norm || is_rx) ? bus_dom : (is_wake && woken_ff);
		end
	endgenerate

	// ==========================================================
	// shared status and chip-level wake effects
	logic [2:0] fail_ff;
	logic       wsrc_ff;
	wire        any_wake   = |wake_ev;
	wire        wake_irq   = any_wake && (chip_stop || chip_normal);
	wire        wake_rst   = any_wake && (chip_sleep || chip_fs);
	wire        wd_on      = any_wake && chip_stop && watchdog_disabled_i
		&& watchdog_on_bus_wake_i;
	wire        fifo_ready;
	wire        ev_push    = any_wake || (|(fail_ev & ~fail_ff));
	wire lmw_event_t ev_rec = '{idx: (wake_ev[0] | fail_ev[0]) ? 2'h0 :
		((wake_ev[1] | fail_ev[1]) ? 2'h1 : 2'h2), wake: any_wake, fail: |fail_ev};

	// flags: a set in the clearing cycle wins
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fail_ff              <= 3'h0;
			wsrc_ff              <= 1'b0;
			interrupt_o          <= 1'b0;
			restart_request_o    <= 1'b0;
			watchdog_enable_o    <= 1'b0;
			lin_receive_out_o    <= 3'h7;
			bus_drive_low_o      <= 3'h0;
			mode_fields_o        <= 6'h0;
			failure_flags_o      <= 3'h0;
			wake_source_status_o <= 1'b0;
			low_slope_select_o   <= LMW_RST_LOW_SLOPE;
			slope_off_o          <= LMW_RST_FLASH;
		end else begin
			fail_ff <= (fail_ff & ~fail_clear_i) | fail_ev;
			wsrc_ff <= (wsrc_ff && !wake_source_clear_i) || any_wake;
			interrupt_o          <= wake_irq;
			restart_request_o    <= wake_rst;
			watchdog_enable_o    <= watchdog_enable_o || wd_on;
			lin_receive_out_o    <= ~rx_n;
			bus_drive_low_o      <= drive_n;
			mode_fields_o        <= {mode_ff[2], mode_ff[1], mode_ff[0]};
			failure_flags_o      <= (fail_ff & ~fail_clear_i) | fail_ev;
			wake_source_status_o <= (wsrc_ff && !wake_source_clear_i) || any_wake;
			low_slope_select_o   <= low_slope_ff;
			slope_off_o          <= flash_ff;
		end
	end

	// ==========================================================
	// event stream; events are dropped when the fifo is full
	lmw_fifo #(
		.WIDTH (LMW_FIFO_W),
		.DEPTH (LMW_FIFO_D)
	) u_fifo (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (ev_push),
		.in_data_i   (ev_rec),
		.in_ready_o  (fifo_ready),
		.out_valid_o (event_valid_o),
		.out_data_o  (event_data_o),
		.out_ready_i (event_ready_i)
	);
endmodule

// [verif/lmw_ctrl_assertions.sv]
// port checker for the LIN mode, wake and fault control
`timescale 1ns/1ps
module lmw_ctrl_assertions
	import lmw_pkg::*;
#(
	parameter int DOM_TO_CYC = LMW_DOM_TO_CYC
) (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	// controls
	input wire lmw_chip_t  chip_mode_i,
	input wire logic       chip_mode_write_i,
	input wire logic       supply_uv_i,
	input wire logic       spi_cs_n_i,
	input wire logic       mode_write_i,
	input wire logic       transmit_timeout_enable_i,
	input wire logic [2:0] fail_clear_i,
	input wire logic       wake_source_clear_i,
	input wire logic [2:0] lin_transmit_in_i,
	// watched outputs
	input wire logic [2:0] lin_receive_out_o,
	input wire logic [2:0] bus_drive_low_o,
	input wire logic [5:0] mode_fields_o,
	input wire logic [2:0] failure_flags_o,
	input wire logic       wake_source_status_o,
	input wire logic       interrupt_o,
	input wire logic       low_slope_select_o,
	input wire logic       slope_off_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// ======
	// length of one unbroken drive while the time-out is armed
	int dom_cnt_ff;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) dom_cnt_ff <= 0;
		else if (bus_drive_low_o[0] && transmit_timeout_enable_i) dom_cnt_ff <= dom_cnt_ff + 1;
		else dom_cnt_ff <= 0;
	end
	// ======
	// rules at the pins, transceiver a stands for all three
	off_no_drive_a: assert property ((mode_fields_o[1:0] == LMW_OFF)[*4]
		|-> !bus_drive_low_o[0]) else $error("driver active in off mode");
	off_no_recv_a: assert property ((mode_fields_o[1:0] == LMW_OFF)[*4]
		|-> lin_receive_out_o[0]) else $error("receive low in off mode");
	rx_only_drive_a: assert property ((mode_fields_o[1:0] == LMW_RXONLY)[*4]
		|-> !bus_drive_low_o[0]) else $error("driver active in receive-only mode");
	idle_tx_drive_a: assert property (lin_transmit_in_i[0][*5]
		|-> !bus_drive_low_o[0]) else $error("bus driven while transmit recessive");
	uv_no_drive_a: assert property (supply_uv_i[*5]
		|-> bus_drive_low_o == 3'h0) else $error("driver active in undervoltage");
	dom_limit_a: assert property (dom_cnt_ff <= DOM_TO_CYC + 6)
		else $error("dominant drive outlasted the time-out");
	fail_sticky_a: assert property (failure_flags_o[0] && !fail_clear_i[0]
		|=> failure_flags_o[0]) else $error("failure flag lost without clear");
	src_sticky_a: assert property (wake_source_status_o && !wake_source_clear_i
		|=> wake_source_status_o) else $error("wake source lost without clear");
	normal_gate_a: assert property ($rose(mode_fields_o[1:0] == LMW_NORMAL)
		|-> $past(chip_mode_i, 2) == LMW_CHIP_NORMAL) else $error("normal mode outside chip normal");
	irq_mode_a: assert property (interrupt_o
		|-> $past(chip_mode_i) inside {LMW_CHIP_NORMAL, LMW_CHIP_STOP})
		else $error("interrupt in wrong mode");
	slope_hold_a: assert property ((!spi_cs_n_i)[*5]
		|-> $stable({low_slope_select_o, slope_off_o})) else $error("slope changed with select low");
	woken_rx_hold_a: assert property ((!(mode_write_i || chip_mode_write_i))[*6]
		##0 (mode_fields_o[1:0] == LMW_WAKE && !lin_receive_out_o[0])
		|=> !lin_receive_out_o[0]) else $error("woken receive released early");
endmodule
bind lmw_ctrl lmw_ctrl_assertions #(.DOM_TO_CYC(DOM_TO_CYC)) chk_u (
	.clk_i, .reset_n_i, .chip_mode_i, .chip_mode_write_i, .supply_uv_i, .spi_cs_n_i,
	.mode_write_i, .transmit_timeout_enable_i, .fail_clear_i, .wake_source_clear_i,
	.lin_transmit_in_i, .lin_receive_out_o, .bus_drive_low_o, .mode_fields_o,
	.failure_flags_o, .wake_source_status_o, .interrupt_o, .low_slope_select_o, .slope_off_o
);

// [verif/lmw_mcu_model.sv]
// microcontroller model driving the three transmit inputs
`timescale 1ns/1ps
module lmw_mcu_model
	import lmw_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	// bench commands
	input  wire logic [2:0] tx_req_i,
	input  wire logic [2:0] early_i,
	// transceiver side
	input  wire logic [5:0] mode_fields_i,
	output logic      [2:0] lin_transmit_in_o
);
	// margin covers the mode field latency
	localparam int WAIT_CYC = LMW_ENABLE_CYC + 8;
	for (genvar g = 0; g < 3; g++) begin : g_x
		logic [11:0] wait_ff;
		wire logic   in_normal;
		wire logic   ready;
		assign in_normal = (mode_fields_i[2*g +: 2] == LMW_NORMAL);
		assign ready = (wait_ff >= WAIT_CYC);
		// count the enabling time from entry to normal mode
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) wait_ff <= 12'h000;
			else if (!in_normal) wait_ff <= 12'h000;
			else if (!ready) wait_ff <= wait_ff + 12'h001;
		end
		// recessive until enabled; an early dominant only when commanded
		assign lin_transmit_in_o[g] = !(tx_req_i[g] && (early_i[g] || ready));
	end
endmodule

// [verif/lmw_ctrl_test.sv]
// self-checking bench for the LIN mode, wake and fault control
`timescale 1ns/1ps
module lmw_ctrl_test
	import lmw_pkg::*;
;
	localparam int DOM = 50; // short time-out keeps the run brief
	// ======
	// stimulus, observed signals and counters
	logic clk_i = 1'h0, reset_n_i = 1'h0, chip_mode_write_i = 1'h0, supply_uv_i = 1'h0;
	logic watchdog_disabled_i = 1'h0, watchdog_on_bus_wake_i = 1'h0, spi_cs_n_i = 1'h1;
	logic mode_write_i = 1'h0, low_slope_wdata_i = 1'h0, flash_wdata_i = 1'h0;
	logic opt_write_i = 1'h0, transmit_timeout_enable_i = 1'h1, wake_source_clear_i = 1'h0;
	logic event_ready_i = 1'h1, irq_seen = 1'h0, rst_seen = 1'h0, seen_clr = 1'h0;
	lmw_chip_t chip_mode_i = LMW_CHIP_NORMAL;
	logic [5:0] mode_wdata_i = 6'h00, ev_cnt = 6'h00;
	logic [2:0] fail_clear_i = 3'h0, ext_bus = 3'h7, tx_req = 3'h0, early = 3'h0;
	logic [2:0] lin_transmit_in_i, lin_receive_out_o, bus_drive_low_o, failure_flags_o;
	logic [5:0] mode_fields_o;
	logic [3:0] event_data_o;
	logic wake_source_status_o, interrupt_o, restart_request_o, watchdog_enable_o;
	logic low_slope_select_o, slope_off_o, event_valid_o;
	wire logic [2:0] bus_level_i;
	int error_cnt = 0, checks_done = 0, cyc_cnt = 0;
	// wired bus: other nodes and our own driver
	assign bus_level_i = ext_bus & ~bus_drive_low_o;
	lmw_ctrl #(.DOM_TO_CYC(DOM)) dut_u (
		.clk_i, .reset_n_i, .chip_mode_i, .chip_mode_write_i, .supply_uv_i,
		.watchdog_disabled_i, .watchdog_on_bus_wake_i, .spi_cs_n_i, .mode_write_i,
		.mode_wdata_i, .low_slope_wdata_i, .flash_wdata_i, .opt_write_i,
		.transmit_timeout_enable_i, .fail_clear_i, .wake_source_clear_i,
		.lin_transmit_in_i, .bus_level_i, .lin_receive_out_o, .bus_drive_low_o,
		.mode_fields_o, .failure_flags_o, .wake_source_status_o, .interrupt_o,
		.restart_request_o, .watchdog_enable_o, .low_slope_select_o, .slope_off_o,
		.event_valid_o, .event_data_o, .event_ready_i);
	lmw_mcu_model mcu_u (.clk_i, .reset_n_i, .tx_req_i(tx_req), .early_i(early),
		.mode_fields_i(mode_fields_o), .lin_transmit_in_o(lin_transmit_in_i));
	always #12.5 clk_i = ~clk_i;
	// pulse catchers, drained beats and hang guard
	always @(posedge clk_i) begin
		if (seen_clr) begin
			irq_seen <= 1'h0;
			rst_seen <= 1'h0;
			ev_cnt   <= 6'h00;
		end else begin
			if (interrupt_o === 1'h1) irq_seen <= 1'h1;
			if (restart_request_o === 1'h1) rst_seen <= 1'h1;
			if (event_valid_o === 1'h1 && event_ready_i) ev_cnt <= ev_cnt + 6'h01;
		end
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	// ======
	// shared tasks
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk_v(input logic [5:0] got, input logic [5:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		chk_v({5'h00, got}, {5'h00, exp});
	endtask
	task automatic cyc(input int n); repeat (n) @(negedge clk_i); endtask
	task automatic clr_seen(); seen_clr = 1'h1; cyc(1); seen_clr = 1'h0; endtask
	task automatic done(input string n); $display("%s finished", n); endtask
	task automatic wr_mode(input logic [5:0] m);
		mode_wdata_i = m; mode_write_i = 1'h1; cyc(1); mode_write_i = 1'h0; cyc(4);
	endtask
	task automatic wr_chip(input lmw_chip_t c);
		chip_mode_i = c; chip_mode_write_i = 1'h1; cyc(1); chip_mode_write_i = 1'h0; cyc(4);
	endtask
	task automatic wr_opt(input logic ls, input logic fl, input logic to);
		low_slope_wdata_i = ls; flash_wdata_i = fl; transmit_timeout_enable_i = to;
		opt_write_i = 1'h1; cyc(1); opt_write_i = 1'h0; cyc(2);
	endtask
	task automatic clr();
		fail_clear_i = 3'h7; wake_source_clear_i = 1'h1; cyc(1);
		fail_clear_i = 3'h0; wake_source_clear_i = 1'h0; cyc(2);
	endtask
	// long dominant then recessive on bus a
	task automatic wake(); ext_bus[0] = 1'h0; cyc(1300); ext_bus[0] = 1'h1; cyc(10); endtask
	// fresh dominant edge on transmit a, then look at the driver
	task automatic tx_edge(input logic exp);
		tx_req[0] = 1'h0; cyc(5); tx_req[0] = 1'h1; cyc(6); chk_b(bus_drive_low_o[0], exp);
		tx_req[0] = 1'h0; cyc(6);
	endtask
	// ======
	// scenarios
	task automatic t_reset();
		chk_v({3'h0, lin_receive_out_o}, 6'h07);
		chk_v({failure_flags_o, bus_drive_low_o}, 6'h00);
		chk_v(mode_fields_o, 6'h00);
		chk_b(low_slope_select_o, LMW_RST_LOW_SLOPE);
		chk_b(slope_off_o, LMW_RST_FLASH);
		ext_bus = 3'h0; cyc(1300); chk_v({3'h0, lin_receive_out_o}, 6'h07);
		ext_bus = 3'h7; cyc(10); chk_b(wake_source_status_o, 1'h0);
		done("reset");
	endtask
	task automatic t_modes();
		wr_chip(LMW_CHIP_STOP); wr_mode(6'h23); chk_v(mode_fields_o, 6'h20);
		wr_chip(LMW_CHIP_SLEEP); wr_mode(6'h00); chk_v(mode_fields_o, 6'h00);
		wr_chip(LMW_CHIP_NORMAL); wr_mode(6'h03); chk_v(mode_fields_o, 6'h03);
		done("modes");
	endtask
	task automatic t_tx();
		// time-out off here, so only the first-edge gate can keep the driver quiet
		wr_opt(1'h0, 1'h0, 1'h0);
		wr_mode(6'h00); tx_req[0] = 1'h1; early[0] = 1'h1; wr_mode(6'h03);
		cyc(500); chk_b(bus_drive_low_o[0], 1'h0);
		early[0] = 1'h0; tx_edge(1'h1); wr_opt(1'h0, 1'h0, 1'h1); clr();
		tx_req[0] = 1'h1; cyc(DOM + 25); chk_b(bus_drive_low_o[0], 1'h0);
		chk_v({3'h0, failure_flags_o}, 6'h01);
		tx_edge(1'h1); wr_opt(1'h0, 1'h0, 1'h0);
		tx_req[0] = 1'h1; cyc(2 * DOM); chk_b(bus_drive_low_o[0], 1'h1);
		tx_req[0] = 1'h0; cyc(4); wr_opt(1'h0, 1'h0, 1'h1); clr();
		supply_uv_i = 1'h1; cyc(6); tx_edge(1'h0);
		ext_bus[0] = 1'h0; cyc(6); chk_b(lin_receive_out_o[0], 1'h0);
		ext_bus[0] = 1'h1; supply_uv_i = 1'h0; cyc(6); tx_edge(1'h1);
		done("transmit");
	endtask
	task automatic t_fifo();
		wr_mode(6'h2A); clr(); event_ready_i = 1'h0;
		repeat (9) begin
			ext_bus[0] = 1'h0; cyc(DOM + 20); chk_b(lin_receive_out_o[0], 1'h0);
			ext_bus[0] = 1'h1; cyc(4); chk_v({3'h0, failure_flags_o}, 6'h01);
			chk_v(mode_fields_o, 6'h2A); clr();
		end
		chk_v({event_valid_o, event_data_o[0]}, 6'h03);
		clr_seen(); event_ready_i = 1'h1; cyc(20); chk_v(ev_cnt, 6'h08);
		done("fifo");
	endtask
	task automatic t_wake();
		wr_mode(6'h01); ext_bus[0] = 1'h0; cyc(600); ext_bus[0] = 1'h1; cyc(10);
		chk_b(lin_receive_out_o[0], 1'h1); clr_seen();
		ext_bus[0] = 1'h0; cyc(1300); chk_b(lin_receive_out_o[0], 1'h1);
		ext_bus[0] = 1'h1; cyc(10); chk_b(lin_receive_out_o[0], 1'h0);
		chk_v(mode_fields_o, 6'h01);
		chk_v({wake_source_status_o, irq_seen}, 6'h03);
		wr_mode(6'h00); wr_mode(6'h01); chk_b(lin_receive_out_o[0], 1'h1);
		wr_chip(LMW_CHIP_SLEEP); clr(); clr_seen(); wake();
		chk_v({rst_seen, irq_seen, wake_source_status_o}, 6'h05);
		chk_b(lin_receive_out_o[0], 1'h0);
		watchdog_disabled_i = 1'h1; watchdog_on_bus_wake_i = 1'h1; wr_chip(LMW_CHIP_STOP);
		chk_v({watchdog_enable_o, lin_receive_out_o[0]}, 6'h01); wake();
		chk_v({watchdog_enable_o, irq_seen}, 6'h03);
		wr_chip(LMW_CHIP_STOP); chk_b(lin_receive_out_o[0], 1'h1);
		wr_chip(LMW_CHIP_FAILSAFE); chk_v(mode_fields_o, 6'h15);
		done("wake");
	endtask
	task automatic t_slope();
		wr_chip(LMW_CHIP_STOP); spi_cs_n_i = 1'h0; wr_opt(1'h1, 1'h1, 1'h1);
		spi_cs_n_i = 1'h1; cyc(6); chk_v({low_slope_select_o, slope_off_o}, 6'h00);
		wr_chip(LMW_CHIP_NORMAL); spi_cs_n_i = 1'h0; wr_opt(1'h1, 1'h1, 1'h1);
		cyc(6); chk_b(low_slope_select_o, 1'h0);
		spi_cs_n_i = 1'h1; cyc(6); chk_v({low_slope_select_o, slope_off_o}, 6'h03);
		done("slope");
	endtask
	// ======
	// main sequence
	initial begin
		cyc(10);
		reset_n_i = 1'h1;
		cyc(1);
		t_reset();
		t_modes();
		t_tx();
		t_fifo();
		t_wake();
		t_slope();
		complete_run();
	end
endmodule
